// ### logic/lcb_pkg.sv
// Package for the LCD clock, segment and bias control block.
// Assumes a single 50 MHz clock and a plain address/strobe register port.
package lcb_pkg;

    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam int SEG_BANKS = 6;
    localparam int DATA_BANKS = 24;

    // Register offsets
    localparam logic [5:0] OFS_DRV_CTRL = 6'h00;
    localparam logic [5:0] OFS_PHASE_PS = 6'h01;
    localparam logic [5:0] OFS_LADDER = 6'h02;
    localparam logic [5:0] OFS_CONTRAST = 6'h03;
    localparam logic [5:0] OFS_SEG_BASE = 6'h08;
    localparam logic [5:0] OFS_DATA_BASE = 6'h20;

    // Field positions
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_SLEEPOFF_BIT = 6;
    localparam int CTRL_CS_LSB = 2;
    localparam int PS_HALF_BIT = 6;
    localparam int PS_ACTIVE_BIT = 5;
    localparam int PS_LP_LSB = 0;
    localparam int LAD_PWR_LSB = 0;

    // Reset values
    localparam logic [7:0] RST_DRV_CTRL = 8'h03;
    localparam logic [7:0] RST_PHASE_PS = 8'h03;
    localparam logic [7:0] RST_ZERO = 8'h00;

    localparam int SYS_DIV = 256;
    localparam logic [7:0] SYS_DIV_LAST = 8'(SYS_DIV - 1);

    typedef enum logic [1:0] {
        LCB_SRC_SYS = 2'b00,
        LCB_SRC_XTAL = 2'b01,
        LCB_SRC_LFINT = 2'b10
    } lcb_src_e;

    typedef enum logic [1:0] {
        LCB_PWR_OFF = 2'b00,
        LCB_PWR_LOW = 2'b01,
        LCB_PWR_MED = 2'b10,
        LCB_PWR_HIGH = 2'b11
    } lcb_pwr_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } lcb_req_s;

    typedef struct packed {
        lcb_pwr_e power;
        logic tapsOn;
        logic halfBypass;
        logic [6:0] contrastShort;
        logic contrastOn;
    } lcb_bias_s;

endpackage : lcb_pkg

// ### logic/lcb_pixel_mem.sv
// Pixel data store, 24 banks of eight bits.
// Assumes writes and reads in the same clock domain; read data are registered.
`timescale 1ns/1ps
module lcb_pixel_mem
    import lcb_pkg::*;
(
    input wire logic clk,
    input wire logic we,
    input wire logic [4:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [4:0] raddr,
    output logic [7:0] rdata,
    output logic [DATA_BANKS*8-1:0] allBits
);
    logic [7:0] mem [DATA_BANKS];

    // Pixel data have no reset value; glass waits for software to fill them
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= (raddr < 5'(DATA_BANKS)) ? mem[raddr] : 8'h00;
    end

    always_comb begin
        for (int i = 0; i < DATA_BANKS; i++) begin
            allBits[i*8 +: 8] = mem[i];
        end
    end
endmodule : lcb_pixel_mem

// ### logic/lcb_top.sv
// LCD clock source select, frame prescaler, segment enables, pixel data and bias control.
// Assumes clk at 50 MHz, srst synchronous, crystal and 31 kHz clocks arriving as pins.
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module lcb_top
    import lcb_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire lcb_req_s req,
    output logic [DATA_W-1:0] rdata,
    input wire logic cpuSleep,
    input wire logic timerCrystalOscillator,
    input wire logic lowFreqInternalOsc,
    output logic frameTick,
    output logic driverActiveFlag,
    output logic [SEG_BANKS*8-1:0] segmentPinSelect,
    output logic [DATA_BANKS*8-1:0] pixelOnBit,
    output lcb_bias_s bias,
    output logic [2:0] externalBiasPinsEn
);

    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [7:0] drvCtrl;
        logic [7:0] phasePs;
        logic [7:0] ladder;
        logic [2:0] contrast;
        logic [2:0] extPins;
        logic [SEG_BANKS*8-1:0] segSel;
        logic [2:0] xtalSync;
        logic [2:0] lfSync;
        logic xtalLevel;
        logic lfLevel;
        logic [7:0] sysDiv;
        logic [3:0] presc;
        logic tick;
        logic rdFromMem;
        logic [7:0] rdReg;
    } lcb_state_s;

    lcb_state_s s_q;
    lcb_state_s s_d;

    logic [7:0] memRdata;
    logic memWe;
    logic [4:0] memWaddr;
    logic srcEdge;
    lcb_src_e srcSel;
    logic active;

    // Bank index relative to a base offset
    function automatic logic [5:0] bankIdx(input logic [5:0] a, input logic [5:0] base);
        bankIdx = a - base;
    endfunction : bankIdx

    function automatic logic inRange(input logic [5:0] a, input logic [5:0] base, input int n);
        inRange = (a >= base) && (a < base + 6'(n));
    endfunction : inRange

    ////////////////////////////////////////////////////////////////////////////
    // Source decode and active flag
    always_comb begin
        unique case (s_q.drvCtrl[CTRL_CS_LSB +: 2])
            2'b00: srcSel = LCB_SRC_SYS;
            2'b01: srcSel = LCB_SRC_XTAL;
            default: srcSel = LCB_SRC_LFINT;
        endcase
    end

    // Sleep only stops the system divided source or a sleep-off setting
    always_comb begin
        active = s_q.drvCtrl[CTRL_EN_BIT]
            && !(cpuSleep && (s_q.drvCtrl[CTRL_SLEEPOFF_BIT] || srcSel == LCB_SRC_SYS));
    end

    always_comb begin
        unique case (srcSel)
            LCB_SRC_SYS: srcEdge = (s_q.sysDiv == SYS_DIV_LAST);
            LCB_SRC_XTAL: srcEdge = (s_q.xtalLevel ^ s_q.xtalSync[1])
                && (s_q.xtalSync[1] == s_q.xtalSync[2]) && s_q.xtalSync[1];
            default: srcEdge = (s_q.lfSync[1] == s_q.lfSync[2]) && s_q.lfSync[1] && !s_q.lfLevel;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        s_d.rdFromMem = 1'b0;
        s_d.rdReg = 8'h00;
        // Pins pass three flops; level accepted when last two agree
        s_d.xtalSync = {s_q.xtalSync[1:0], timerCrystalOscillator};
        s_d.lfSync = {s_q.lfSync[1:0], lowFreqInternalOsc};
        if (s_q.xtalSync[1] == s_q.xtalSync[2]) begin
            s_d.xtalLevel = s_q.xtalSync[1];
        end
        if (s_q.lfSync[1] == s_q.lfSync[2]) begin
            s_d.lfLevel = s_q.lfSync[1];
        end
        s_d.sysDiv = s_q.sysDiv + 8'h01;

        // Prescaler runs only while the driver is active
        if (!active) begin
            s_d.presc = 4'h0;
        end else if (srcEdge) begin
            if (s_q.presc >= s_q.phasePs[PS_LP_LSB +: 4]) begin
                s_d.presc = 4'h0;
                s_d.tick = 1'b1;
            end else begin
                s_d.presc = s_q.presc + 4'h1;
            end
        end

        if (req.wr) begin
            if (req.addr == OFS_DRV_CTRL) begin
                s_d.drvCtrl = req.wdata & 8'hCF;
            end else if (req.addr == OFS_PHASE_PS) begin
                // Active and write-allow bits are status only
                s_d.phasePs = req.wdata & 8'hCF;
            end else if (req.addr == OFS_LADDER) begin
                s_d.ladder = {req.wdata[7:1], 1'b0};
                s_d.extPins = req.wdata[3:1];
            end else if (req.addr == OFS_CONTRAST) begin
                s_d.contrast = req.wdata[2:0];
            end else if (inRange(req.addr, OFS_SEG_BASE, SEG_BANKS)) begin
                s_d.segSel[3'(bankIdx(req.addr, OFS_SEG_BASE))*8 +: 8] = req.wdata;
            end
        end

        if (req.rd) begin
            if (req.addr == OFS_DRV_CTRL) begin
                s_d.rdReg = s_q.drvCtrl;
            end else if (req.addr == OFS_PHASE_PS) begin
                s_d.rdReg = s_q.phasePs;
                s_d.rdReg[PS_ACTIVE_BIT] = active;
            end else if (req.addr == OFS_LADDER) begin
                s_d.rdReg = {s_q.ladder[7:4], s_q.extPins, 1'b0};
            end else if (req.addr == OFS_CONTRAST) begin
                s_d.rdReg = {5'h00, s_q.contrast};
            end else if (inRange(req.addr, OFS_SEG_BASE, SEG_BANKS)) begin
                s_d.rdReg = s_q.segSel[3'(bankIdx(req.addr, OFS_SEG_BASE))*8 +: 8];
            end else if (inRange(req.addr, OFS_DATA_BASE, DATA_BANKS)) begin
                s_d.rdFromMem = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '0;
            s_q.drvCtrl <= RST_DRV_CTRL;
            s_q.phasePs <= RST_PHASE_PS;
            s_q.ladder <= RST_ZERO;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pixel store
    assign memWe = req.wr && inRange(req.addr, OFS_DATA_BASE, DATA_BANKS);
    assign memWaddr = 5'(bankIdx(req.addr, OFS_DATA_BASE));

    lcb_pixel_mem u_mem (
        .clk(clk),
        .we(memWe),
        .waddr(memWaddr),
        .wdata(req.wdata),
        .raddr(5'(bankIdx(req.addr, OFS_DATA_BASE))),
        .rdata(memRdata),
        .allBits(pixelOnBit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign rdata = s_q.rdFromMem ? memRdata : s_q.rdReg;
    assign frameTick = s_q.tick;
    assign driverActiveFlag = active;
    assign segmentPinSelect = s_q.segSel;
    // External pins controlled independently of the internal ladder
    assign externalBiasPinsEn = s_q.extPins;

    always_comb begin
        bias.power = active ? lcb_pwr_e'(s_q.ladder[5:4]) : LCB_PWR_OFF;
        bias.tapsOn = (bias.power != LCB_PWR_OFF);
        // Three-resistor ladder; middle shorted in half bias
        bias.halfBypass = s_q.phasePs[PS_HALF_BIT];
        bias.contrastOn = active;
        // Thermometer: k segments of seven left in circuit
        for (int i = 0; i < 7; i++) begin
            bias.contrastShort[i] = (3'(i) >= s_q.contrast);
        end
    end

endmodule : lcb_top

// ### bench/lcb_glass.sv
// Passive glass model on the segment side.
// Assumes bank 0 of select and pixel data.
`timescale 1ns/1ps
module lcb_glass
    import lcb_pkg::*;
(
    input logic [SEG_BANKS*8-1:0] segmentPinSelect,
    input logic [DATA_BANKS*8-1:0] pixelOnBit,
    output logic [7:0] darkCom0
);
    // Pins left to plain I/O never show a pixel
    assign darkCom0 = pixelOnBit[7:0] & segmentPinSelect[7:0];
endmodule : lcb_glass

// ### bench/lcb_top_props.sv
// Port checker for lcb_top.
// Assumes bind onto lcb_top, single clock.
`timescale 1ns/1ps
module lcb_top_chk
    import lcb_pkg::*;
(
    input logic clk,
    input logic srst,
    input lcb_req_s req,
    input logic [DATA_W-1:0] rdata,
    input logic frameTick,
    input logic driverActiveFlag,
    input logic [SEG_BANKS*8-1:0] segmentPinSelect,
    input lcb_bias_s bias,
    input logic [2:0] externalBiasPinsEn
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence wrAt(logic [5:0] a);
        req.wr && req.addr == a;
    endsequence
    // Tick register may still hold one late pulse
    sequence idle3;
        !driverActiveFlag [*3];
    endsequence
    a_contrast_code: assert property (wrAt(OFS_CONTRAST) |=>
        $countones(~bias.contrastShort) == $past(req.wdata[2:0])) else $error("contrast code");
    a_seg_bank0: assert property (wrAt(OFS_SEG_BASE) |=>
        segmentPinSelect[7:0] == $past(req.wdata)) else $error("segment select");
    a_half_bias: assert property (wrAt(OFS_PHASE_PS) |=>
        bias.halfBypass == $past(req.wdata[PS_HALF_BIT])) else $error("half bias");
    a_ext_pins: assert property (wrAt(OFS_LADDER) |=>
        externalBiasPinsEn == $past(req.wdata[3:1])) else $error("bias pin enables");
    a_ladder_off: assert property (!driverActiveFlag |->
        bias.power == LCB_PWR_OFF && !bias.tapsOn) else $error("ladder not off");
    a_tick_single: assert property (frameTick |=> !frameTick) else $error("tick too long");
    a_tick_idle: assert property (idle3 |-> !frameTick) else $error("tick while idle");
    a_active_read: assert property (req.rd && req.addr == OFS_PHASE_PS |=>
        rdata[PS_ACTIVE_BIT] == $past(driverActiveFlag)) else $error("active flag read");
    a_read_idle: assert property (!req.rd |=> rdata == '0) else $error("stray read data");
endmodule : lcb_top_chk
bind lcb_top lcb_top_chk chk_u (.clk(clk), .srst(srst), .req(req), .rdata(rdata),
    .frameTick(frameTick), .driverActiveFlag(driverActiveFlag),
    .segmentPinSelect(segmentPinSelect), .bias(bias), .externalBiasPinsEn(externalBiasPinsEn));

// ### bench/lcb_top_tb.sv
// Testbench for lcb_top with glass model.
// Assumes 50 MHz clk, pin clocks on exact clk multiples.
`timescale 1ns/1ps
module lcb_top_tb
    import lcb_pkg::*;
;
    logic clk = 0, srst = 1, cpuSleep = 0, xtal = 0, lfint = 0;
    lcb_req_s req = '0;
    logic [7:0] rdata, dark;
    logic frameTick, active;
    logic [47:0] segSel;
    logic [191:0] pixels;
    lcb_bias_s bias;
    logic [2:0] extEn;
    int fails = 0, checks = 0;
    initial forever #10 clk = ~clk;
    // Offset keeps pin edges away from clk edges
    initial begin #3; forever #200 xtal = ~xtal; end
    initial begin #7; forever #320 lfint = ~lfint; end
    lcb_top dut_u (.clk(clk), .srst(srst), .req(req), .rdata(rdata), .cpuSleep(cpuSleep),
        .timerCrystalOscillator(xtal), .lowFreqInternalOsc(lfint), .frameTick(frameTick),
        .driverActiveFlag(active), .segmentPinSelect(segSel), .pixelOnBit(pixels), .bias(bias),
        .externalBiasPinsEn(extEn));
    lcb_glass glass_u (.segmentPinSelect(segSel), .pixelOnBit(pixels), .darkCom0(dark));
    ////////////////////////////////////////////////////////////
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(logic [5:0] a, logic [7:0] d);
        @(posedge clk);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(logic [5:0] a, logic [7:0] exp);
        @(posedge clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        check("rdata", 16'(rdata), 16'(exp));
    endtask : rd
    // Disable first so the prescaler restarts clean
    task automatic cfg(logic [1:0] src, logic [3:0] p);
        wr(OFS_DRV_CTRL, 8'h00);
        wr(OFS_PHASE_PS, 8'(p));
        wr(OFS_DRV_CTRL, 8'h80 | 8'(src) << 2);
    endtask : cfg
    task automatic gap(logic [15:0] exp);
        int n;
        n = 0;
        while (frameTick !== 1'b1 && n < 9000) begin @(posedge clk); #1; n++; end
        n = 0;
        do begin @(posedge clk); #1; n++; end while (frameTick !== 1'b1 && n < 9000);
        check("tick gap", 16'(n), exp);
    endtask : gap
    task automatic test_done;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : test_done
    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        test_done;
    end
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        rd(OFS_DRV_CTRL, RST_DRV_CTRL);
        rd(OFS_PHASE_PS, RST_PHASE_PS);
        rd(OFS_LADDER, RST_ZERO);
        wr(6'h3F, 8'hFF);
        rd(6'h3F, RST_ZERO);
        for (int k = 0; k < 8; k++) begin
            wr(OFS_CONTRAST, 8'hF8 | 8'(k));
            rd(OFS_CONTRAST, 8'(k));
            check("contrast", 16'($countones(~bias.contrastShort)), 16'(k));
        end
        wr(OFS_SEG_BASE + 6'd5, 8'hA5);
        check("seg bank5", 16'(segSel[47:40]), 16'h00A5);
        wr(OFS_DATA_BASE, 8'h3C);
        wr(OFS_SEG_BASE, 8'h0F);
        check("dark com0", 16'(dark), 16'h000C);
        wr(OFS_DATA_BASE + 6'd23, 8'h81);
        check("pixel bank23", 16'(pixels[191:184]), 16'h0081);
        rd(OFS_DATA_BASE + 6'd23, 8'h81);
        rd(OFS_DATA_BASE, 8'h3C);
        cfg(2'b00, 4'h0);
        gap(16'd256);
        cfg(2'b00, 4'hF);
        gap(16'd4096);
        cfg(2'b01, 4'h1);
        gap(16'd40);
        cfg(2'b10, 4'h2);
        gap(16'd96);
        cfg(2'b11, 4'h0);
        gap(16'd32);
        rd(OFS_PHASE_PS, 8'h20);
        for (int k = 0; k < 4; k++) begin
            wr(OFS_LADDER, 8'(k << 4) | 8'h0E);
            check("ladder power", 16'(bias.power), 16'(k));
            check("taps on", 16'(bias.tapsOn), 16'(k != 0));
        end
        check("ext pins", 16'(extEn), 16'h0007);
        check("contrast on", 16'(bias.contrastOn), 16'h0001);
        check("third bias", 16'(bias.halfBypass), 16'h0000);
        wr(OFS_PHASE_PS, 8'h40);
        check("half bypass", 16'(bias.halfBypass), 16'h0001);
        @(posedge clk);
        cpuSleep <= 1'b1;
        @(posedge clk);
        #1;
        check("sleep active", 16'(active), 16'h0001);
        wr(OFS_DRV_CTRL, 8'h80);
        check("sleep sys", 16'(active), 16'h0000);
        check("forced off", 16'(bias.power), 16'h0000);
        check("contrast off", 16'(bias.contrastOn), 16'h0000);
        wr(OFS_DRV_CTRL, 8'h84);
        check("sleep xtal", 16'(active), 16'h0001);
        wr(OFS_DRV_CTRL, 8'hC4);
        check("sleep off", 16'(active), 16'h0000);
        check("taps off", 16'(bias.tapsOn), 16'h0000);
        rd(OFS_PHASE_PS, 8'h40);
        test_done;
    end
endmodule : lcb_top_tb
